// ### rar_pkg.sv
// rar_pkg: constants for the routing action resolver output stage
// assumes: shared by the stage module and its testbench
package rar_pkg;

    // --------------------
    // channel widths
    // --------------------
    localparam int FLAG_W      = 52;
    localparam int FLAG_EXT_W  = 16;
    localparam int FLAG_OUT_W  = 68;
    localparam int NSETS       = 4;
    localparam int QOS_IN_W    = 24;
    localparam int QOS_OUT_W   = 34;
    localparam int MAP1_W      = 4;
    localparam int MAP2_W      = 6;
    localparam int TAG_W       = 16;
    localparam int CTAG_W      = 12;
    localparam int VID_W       = 12;
    localparam int MAC_W       = 48;
    localparam int FID_W       = 12;
    localparam int FID_ALL_W   = 48;
    localparam int ALU_W       = 16;
    localparam int ALU_ALL_W   = 192;
    localparam int POL12_W     = 12;
    localparam int POL3_W      = 10;
    localparam int LKP_PROF_W  = 4;
    localparam int ALU_PROF_W  = 5;
    localparam int MASK_PROF_W = 4;
    localparam int HASH_PROF_W = 4;
    localparam int HROT_W      = 20;
    localparam int W8_ALL_W    = 32;
    localparam int W8_W        = 8;
    localparam int W16_ALL_W   = 112;

    // --------------------
    // flag vector bit positions
    // --------------------
    localparam int EGR_LO      = 0;
    localparam int EGR_HI      = 23;
    localparam int SCR_LO      = 24;
    localparam int SCR_HI      = 32;
    localparam int STRICT_BIT  = 33;
    localparam int PAUSE_LO    = 34;
    localparam int PAUSE_HI    = 35;
    localparam int ERR_LO      = 36;
    localparam int ERR_HI      = 38;
    localparam int FAULT_BIT   = 39;
    localparam int FIXED_LO    = 40;
    localparam int FIXED_HI    = 51;

    // --------------------
    // register map (byte addresses) and fields
    // --------------------
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_FRAMES   = 4'h8;
    localparam int          CTRL_ACT_EN  = 0;
    localparam int          CTRL_PAUSE   = 1;
    localparam int          CTRL_FOLD    = 2;
    localparam logic [2:0]  CTRL_RESET   = 3'h7;
    localparam int          STAT_FAULT   = 0;
    localparam logic [15:0] FRAMES_RESET = 16'h0000;

endpackage

// ### rar_stage.sv
// rar_stage: output stage of the routing action resolver
// assumes: one frame beat per in_valid cycle, channels already muxed upstream,
//          classic wishbone master on the register port, one clock domain
//
// Overview of operation
// R01: flag action: flags and mask, or value
// R02: flags ripple through sets; untouched bits kept
// R03: bits 23:0 carried out as egress flags
// R04: bits 32:24 scratch, out as scheduler flags
// R05: bit 33 drives strict destination tag mapping
// R06: bits 35:34 feed pause reception logic
// R07: bits 38:36 parser errors; 39 integrity fault
// R08: software may fold errors into bit 39
// R09: bits 51:40 fixed-function, may be redefined
// R10: flag vector widened by 16 bits after
// R11: qos widened 24 to 34 with indices
// R12: 4-bit and 6-bit policer map indices
// R13: 12-bit canonical source tag from source tag
// R14: 48-bit destination and source mac keys
// R15: four 12-bit filtering id key fields
// R16: twelve 16-bit alu operands for six alus
// R17: policer indices 12, 12 and 10 bits
// R18: lookup, alu, mask and hash profiles out
// R19: 20-bit hash rotation select output
// R20: generic action data channels output
// R21: care needed writing fixed-function flag bits
// R22: later precedence set overrides earlier one
// R23: all channels presented together with valid
//
// The Wishbone slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module rar_stage (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 srst,
    // wishbone register port
    input  wire logic                                 wb_cyc_i,
    input  wire logic                                 wb_stb_i,
    input  wire logic                                 wb_we_i,
    input  wire logic [3:0]                           wb_adr_i,
    input  wire logic [3:0]                           wb_sel_i,
    input  wire logic [31:0]                          wb_dat_i,
    output logic      [31:0]                          wb_dat_o,
    output logic                                      wb_ack_o,
    // frame beat qualifier and flags
    input  wire logic                                 in_valid,
    input  wire logic [rar_pkg::FLAG_W-1:0]           in_flags,
    input  wire logic [rar_pkg::FLAG_EXT_W-1:0]       in_flags_ext,
    input  wire logic                                 sram_fault,
    // flag write actions, one per precedence set
    input  wire logic [rar_pkg::NSETS-1:0]            flag_act_en,
    input  wire logic [rar_pkg::NSETS*rar_pkg::FLAG_W-1:0] flag_act_mask,
    input  wire logic [rar_pkg::NSETS*rar_pkg::FLAG_W-1:0] flag_act_value,
    // command profile actions, one per precedence set
    input  wire logic [rar_pkg::NSETS-1:0]            lkp_prof_en,
    input  wire logic [rar_pkg::NSETS*rar_pkg::LKP_PROF_W-1:0] lkp_prof_set,
    input  wire logic [rar_pkg::NSETS-1:0]            alu13_prof_en,
    input  wire logic [rar_pkg::NSETS*rar_pkg::ALU_PROF_W-1:0] alu13_prof_set,
    input  wire logic [rar_pkg::NSETS-1:0]            alu46_prof_en,
    input  wire logic [rar_pkg::NSETS*rar_pkg::ALU_PROF_W-1:0] alu46_prof_set,
    input  wire logic [rar_pkg::NSETS-1:0]            mask_prof_en,
    input  wire logic [rar_pkg::NSETS*rar_pkg::MASK_PROF_W-1:0] mask_prof_set,
    input  wire logic [rar_pkg::NSETS-1:0]            hash_prof_en,
    input  wire logic [rar_pkg::NSETS*rar_pkg::HASH_PROF_W-1:0] hash_prof_set,
    // muxed channels from the action mux pathways
    input  wire logic [rar_pkg::QOS_IN_W-1:0]         in_qos,
    input  wire logic [rar_pkg::MAP1_W-1:0]           in_policer_map_one_index,
    input  wire logic [rar_pkg::MAP2_W-1:0]           in_policer_map_two_index,
    input  wire logic [rar_pkg::TAG_W-1:0]            in_dest_port_tag,
    input  wire logic [rar_pkg::TAG_W-1:0]            in_src_port_tag,
    input  wire logic                                 in_ctag_sel,
    input  wire logic [rar_pkg::CTAG_W-1:0]           in_ctag_value,
    input  wire logic [4*rar_pkg::VID_W-1:0]          in_vids,
    input  wire logic [rar_pkg::MAC_W-1:0]            in_dest_mac_key,
    input  wire logic [rar_pkg::MAC_W-1:0]            in_src_mac_key,
    input  wire logic [rar_pkg::FID_ALL_W-1:0]        in_filtering_ids,
    input  wire logic [rar_pkg::ALU_ALL_W-1:0]        in_alu_ops,
    input  wire logic [rar_pkg::POL12_W-1:0]          in_pol1_idx,
    input  wire logic [rar_pkg::POL12_W-1:0]          in_pol2_idx,
    input  wire logic [rar_pkg::POL3_W-1:0]           in_pol3_idx,
    input  wire logic [rar_pkg::HROT_W-1:0]           in_hash_rotation_select,
    input  wire logic [rar_pkg::W8_ALL_W-1:0]         in_data_w8,
    input  wire logic [rar_pkg::W8_W-1:0]             in_cpu_code,
    input  wire logic [rar_pkg::W8_W-1:0]             in_qos_vis,
    input  wire logic [rar_pkg::W16_ALL_W-1:0]        in_data_w16,
    // downstream frame beat
    output logic                                      out_valid,
    output logic      [rar_pkg::FLAG_OUT_W-1:0]       out_flags,
    output logic      [rar_pkg::EGR_HI:0]             egress_modify_flags,
    output logic      [rar_pkg::SCR_HI-rar_pkg::SCR_LO:0] sched_flags,
    output logic                                      strict_dest_tag_mapping,
    output logic      [1:0]                           pause_rx_ctrl,
    output logic                                      sram_integrity_fault_bit,
    output logic      [rar_pkg::QOS_OUT_W-1:0]        out_qos,
    output logic      [rar_pkg::TAG_W-1:0]            dest_port_tag,
    output logic      [rar_pkg::TAG_W-1:0]            src_port_tag,
    output logic      [rar_pkg::CTAG_W-1:0]           canonical_src_port_tag,
    output logic      [4*rar_pkg::VID_W-1:0]          out_vids,
    output logic      [rar_pkg::MAC_W-1:0]            dest_mac_lookup_key,
    output logic      [rar_pkg::MAC_W-1:0]            src_mac_lookup_key,
    output logic      [rar_pkg::FID_ALL_W-1:0]        filtering_id_keys,
    output logic      [rar_pkg::ALU_ALL_W-1:0]        alu_operands,
    output logic      [rar_pkg::POL12_W-1:0]          pol1_idx,
    output logic      [rar_pkg::POL12_W-1:0]          pol2_idx,
    output logic      [rar_pkg::POL3_W-1:0]           pol3_idx,
    output logic      [rar_pkg::LKP_PROF_W-1:0]       lkp_profile,
    output logic      [rar_pkg::ALU_PROF_W-1:0]       alu13_profile,
    output logic      [rar_pkg::ALU_PROF_W-1:0]       alu46_profile,
    output logic      [rar_pkg::MASK_PROF_W-1:0]      mask_profile,
    output logic      [rar_pkg::HASH_PROF_W-1:0]      hash_profile,
    output logic      [rar_pkg::HROT_W-1:0]           hash_rotation_select,
    output logic      [rar_pkg::W8_ALL_W-1:0]         data_w8,
    output logic      [rar_pkg::W8_W-1:0]             cpu_code,
    output logic      [rar_pkg::W8_W-1:0]             qos_vis,
    output logic      [rar_pkg::W16_ALL_W-1:0]        data_w16
);
    import rar_pkg::*;

    // --------------------
    // functions
    // --------------------

    // one flag write action: keep masked bits, then set value bits
    function automatic logic [FLAG_W-1:0] flag_write(input logic [FLAG_W-1:0] f,
                                                     input logic [FLAG_W-1:0] m,
                                                     input logic [FLAG_W-1:0] v);
        flag_write = (f & m) | v; // [R01]
    endfunction

    // last enabled set wins; profile defaults to zero when none writes it
    function automatic logic [7:0] last_set(input logic [NSETS-1:0] en,
                                            input logic [NSETS*8-1:0] vals);
        last_set = 8'h00;
        for (int i = 0; i < NSETS; i++) begin
            if (en[i]) begin
                last_set = vals[i*8 +: 8]; // [R22]
            end
        end
    endfunction

    // widen a packed profile array to eight bits per set
    function automatic logic [NSETS*8-1:0] widen(input logic [NSETS*8-1:0] packed_v,
                                                 input int w);
        widen = '0;
        for (int i = 0; i < NSETS; i++) begin
            for (int b = 0; b < w; b++) begin
                widen[i*8 + b] = packed_v[i*w + b];
            end
        end
    endfunction

    // --------------------
    // register state
    // --------------------
    logic [2:0]  ctrl_q;
    logic [2:0]  ctrl_d;
    logic        fault_seen_q;
    logic        fault_seen_d;
    logic [15:0] frames_q;
    logic [15:0] frames_d;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // --------------------
    // wishbone decode
    // --------------------

    // request strobes; ack falls the cycle after it is given
    wire         wb_req    = wb_cyc_i & wb_stb_i & ~ack_q;
    wire         wr_ctrl   = wb_req & wb_we_i & (wb_adr_i == REG_CTRL) & wb_sel_i[0];
    wire         wr_status = wb_req & wb_we_i & (wb_adr_i == REG_STATUS) & wb_sel_i[0];
    wire         clr_fault = wr_status & wb_dat_i[STAT_FAULT];
    wire         act_en    = ctrl_q[CTRL_ACT_EN];
    wire         pause_hold = ctrl_q[CTRL_PAUSE];
    wire         fold_err  = ctrl_q[CTRL_FOLD];

    // read data mux; unmapped offsets read zero
    assign rdata_d = (wb_adr_i == REG_CTRL)   ? {29'h0000_0000, ctrl_q} :
                     (wb_adr_i == REG_STATUS) ? {31'h0000_0000, fault_seen_q} :
                     (wb_adr_i == REG_FRAMES) ? {16'h0000, frames_q} :
                                                32'h0000_0000;
    assign ctrl_d  = wr_ctrl ? wb_dat_i[2:0] : ctrl_q;

    // --------------------
    // flag vector resolution
    // --------------------
    logic [FLAG_W-1:0] flags_chain;
    logic [FLAG_W-1:0] flags_fixed;

    // serial ripple through precedence sets, starting from the input vector
    always_comb begin
        flags_chain = in_flags; // [R02]
        for (int i = 0; i < NSETS; i++) begin
            if (act_en && flag_act_en[i]) begin
                flags_chain = flag_write(flags_chain,
                                         flag_act_mask[i*FLAG_W +: FLAG_W],
                                         flag_act_value[i*FLAG_W +: FLAG_W]); // [R01] [R22]
            end
        end
    end

    // fixed-function post edits: pause protection, error folding, integrity fault
    always_comb begin
        flags_fixed = flags_chain;
        if (pause_hold) begin
            flags_fixed[PAUSE_HI:PAUSE_LO] = in_flags[PAUSE_HI:PAUSE_LO]; // [R06]
        end
        if (fold_err) begin
            flags_fixed[FAULT_BIT] = flags_chain[FAULT_BIT] |
                                     (|flags_chain[ERR_HI:ERR_LO]); // [R08]
            flags_fixed[ERR_HI:ERR_LO] = 3'h0;
        end
        if (sram_fault) begin
            flags_fixed[FAULT_BIT] = 1'b1; // [R07]
        end
    end

    // --------------------
    // command profile resolution
    // --------------------
    logic [7:0] lkp_sel;
    logic [7:0] alu13_sel;
    logic [7:0] alu46_sel;
    logic [7:0] mask_sel;
    logic [7:0] hash_sel;

    // each profile taken from the last precedence set that wrote it
    assign lkp_sel   = last_set(lkp_prof_en,
                                widen({16'h0000, lkp_prof_set}, LKP_PROF_W)); // [R18]
    assign alu13_sel = last_set(alu13_prof_en,
                                widen({12'h000, alu13_prof_set}, ALU_PROF_W)); // [R18]
    assign alu46_sel = last_set(alu46_prof_en,
                                widen({12'h000, alu46_prof_set}, ALU_PROF_W)); // [R18]
    assign mask_sel  = last_set(mask_prof_en,
                                widen({16'h0000, mask_prof_set}, MASK_PROF_W)); // [R18]
    assign hash_sel  = last_set(hash_prof_en,
                                widen({16'h0000, hash_prof_set}, HASH_PROF_W)); // [R18]

    // --------------------
    // register and bus processes
    // --------------------

    // sticky fault: a new fault in the clear cycle wins
    assign fault_seen_d = (in_valid & flags_fixed[FAULT_BIT]) |
                          (fault_seen_q & ~clr_fault);
    assign frames_d     = in_valid ? frames_q + 16'h0001 : frames_q;

    // control, status and bus answer
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q       <= CTRL_RESET;
            fault_seen_q <= 1'b0;
            frames_q     <= FRAMES_RESET;
            ack_q        <= 1'b0;
            rdata_q      <= 32'h0000_0000;
        end else begin
            ctrl_q       <= ctrl_d;
            fault_seen_q <= fault_seen_d;
            frames_q     <= frames_d;
            ack_q        <= wb_req;
            rdata_q      <= rdata_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // --------------------
    // output beat: every channel registered on the same edge
    // --------------------

    // valid qualifier and flag vector
    always_ff @(posedge clk) begin
        if (srst) begin
            out_valid <= 1'b0;
            out_flags <= '0;
        end else begin
            out_valid <= in_valid; // [R23]
            out_flags <= {in_flags_ext, flags_fixed}; // [R10] [R09]
        end
    end

    // flag field views follow the registered vector
    assign egress_modify_flags      = out_flags[EGR_HI:EGR_LO]; // [R03]
    assign sched_flags              = out_flags[SCR_HI:SCR_LO]; // [R04]
    assign strict_dest_tag_mapping  = out_flags[STRICT_BIT]; // [R05]
    assign pause_rx_ctrl            = out_flags[PAUSE_HI:PAUSE_LO]; // [R06]
    assign sram_integrity_fault_bit = out_flags[FAULT_BIT]; // [R07]

    // qos, tags, vids and lookup keys
    always_ff @(posedge clk) begin
        if (srst) begin
            out_qos                <= '0;
            dest_port_tag          <= '0;
            src_port_tag           <= '0;
            canonical_src_port_tag <= '0;
            out_vids               <= '0;
            dest_mac_lookup_key    <= '0;
            src_mac_lookup_key     <= '0;
            filtering_id_keys      <= '0;
        end else if (in_valid) begin
            out_qos                <= {in_policer_map_two_index, in_policer_map_one_index, in_qos}; // [R11] [R12]
            dest_port_tag          <= in_dest_port_tag;
            src_port_tag           <= in_src_port_tag;
            canonical_src_port_tag <= in_ctag_sel ? in_ctag_value
                                                  : in_src_port_tag[CTAG_W-1:0]; // [R13]
            out_vids               <= in_vids;
            dest_mac_lookup_key    <= in_dest_mac_key; // [R14]
            src_mac_lookup_key     <= in_src_mac_key; // [R14]
            filtering_id_keys      <= in_filtering_ids; // [R15]
        end
    end

    // alu operands, policer indices and profiles
    always_ff @(posedge clk) begin
        if (srst) begin
            alu_operands         <= '0;
            pol1_idx             <= '0;
            pol2_idx             <= '0;
            pol3_idx             <= '0;
            lkp_profile          <= '0;
            alu13_profile        <= '0;
            alu46_profile        <= '0;
            mask_profile         <= '0;
            hash_profile         <= '0;
            hash_rotation_select <= '0;
        end else if (in_valid) begin
            alu_operands         <= in_alu_ops; // [R16]
            pol1_idx             <= in_pol1_idx; // [R17]
            pol2_idx             <= in_pol2_idx; // [R17]
            pol3_idx             <= in_pol3_idx; // [R17]
            lkp_profile          <= lkp_sel[LKP_PROF_W-1:0]; // [R18]
            alu13_profile        <= alu13_sel[ALU_PROF_W-1:0]; // [R18]
            alu46_profile        <= alu46_sel[ALU_PROF_W-1:0]; // [R18]
            mask_profile         <= mask_sel[MASK_PROF_W-1:0]; // [R18]
            hash_profile         <= hash_sel[HASH_PROF_W-1:0]; // [R18]
            hash_rotation_select <= in_hash_rotation_select; // [R19]
        end
    end

    // generic action data
    always_ff @(posedge clk) begin
        if (srst) begin
            data_w8  <= '0;
            cpu_code <= '0;
            qos_vis  <= '0;
            data_w16 <= '0;
        end else if (in_valid) begin
            data_w8  <= in_data_w8; // [R20]
            cpu_code <= in_cpu_code; // [R20]
            qos_vis  <= in_qos_vis; // [R20]
            data_w16 <= in_data_w16; // [R20]
        end
    end

endmodule

// ### rar_chk.sv
// rar_chk: concurrent checks on the routing action resolver output stage
// assumes: bound to rar_stage, single clock, srst synchronous active high
`timescale 1ns/1ps

module rar_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // inputs watched
    input wire logic        in_valid,
    input wire logic        sram_fault,
    input wire logic [15:0] in_flags_ext,
    input wire logic [23:0] in_qos,
    input wire logic [3:0]  in_policer_map_one_index,
    input wire logic [5:0]  in_policer_map_two_index,
    // outputs watched
    input wire logic        wb_ack_o,
    input wire logic        out_valid,
    input wire logic [67:0] out_flags,
    input wire logic [23:0] egress_modify_flags,
    input wire logic [8:0]  sched_flags,
    input wire logic        strict_dest_tag_mapping,
    input wire logic [1:0]  pause_rx_ctrl,
    input wire logic        sram_integrity_fault_bit,
    input wire logic [33:0] out_qos
);
    // --------------------
    // assertions
    // --------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    valid_latency_a: assert property (in_valid |=> out_valid)
        else $error("no out_valid");
    valid_pulse_a: assert property (!in_valid |=> !out_valid)
        else $error("stray out_valid");
    egress_slice_a: assert property (egress_modify_flags == out_flags[23:0])
        else $error("egress slice");
    sched_slice_a: assert property (sched_flags == out_flags[32:24])
        else $error("sched slice");
    strict_pause_a: assert property (strict_dest_tag_mapping == out_flags[33]
        && pause_rx_ctrl == out_flags[35:34])
        else $error("strict or pause slice");
    fault_force_a: assert property (sram_fault |=> out_flags[39] && sram_integrity_fault_bit)
        else $error("bit 39 not set");
    ext_append_a: assert property (!$past(srst) |-> out_flags[67:52] == $past(in_flags_ext))
        else $error("ext flags");
    qos_pack_a: assert property (in_valid |=>
        out_qos == {$past(in_policer_map_two_index), $past(in_policer_map_one_index), $past(in_qos)})
        else $error("qos packing");
    qos_hold_a: assert property (!in_valid |=> $stable(out_qos))
        else $error("qos moved");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");

    // main scenarios reached
    back_to_back_c: cover property (in_valid ##1 in_valid);
    fault_beat_c: cover property (in_valid && sram_fault);
    bus_ack_c: cover property (wb_ack_o);
endmodule

// ### rar_sink.sv
// rar_sink: downstream stage model that takes each resolved frame beat
// assumes: one beat per out_valid cycle, no backpressure toward the stage
`timescale 1ns/1ps

module rar_sink (
    // clock and reset
    input wire logic         clk,
    input wire logic         srst,
    // frame beat from the stage
    input wire logic         out_valid,
    input wire logic [67:0]  out_flags,
    input wire logic [33:0]  out_qos,
    input wire logic [3:0]   lkp_profile,
    input wire logic [11:0]  canonical_src_port_tag,
    // captured beat for the bench
    output logic             got,
    output logic [117:0]     cap
);
    // latch all channels together on the valid beat; cap inverts on every cycle without out_valid
    always_ff @(posedge clk) begin
        got <= out_valid & ~srst;
        cap <= out_valid ? {out_flags, out_qos, lkp_profile, canonical_src_port_tag} : ~cap;
    end
endmodule

// ### rar_stage_tb.sv
// rar_stage_tb: random frame beats and register traffic against a reference
// assumes: rar_stage, rar_chk and rar_sink compiled before this file
`timescale 1ns/1ps

module rar_stage_tb;
    import rar_pkg::*;
    // --------------------
    // signals
    // --------------------
    logic clk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, in_valid = 0;
    logic wb_ack_o, sram_fault, in_ctag_sel, out_valid, got, strict_dest_tag_mapping;
    logic sram_integrity_fault_bit;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
    logic [3:0] flag_act_en, lkp_prof_en, alu13_prof_en, alu46_prof_en, mask_prof_en;
    logic [3:0] hash_prof_en, in_policer_map_one_index, lkp_profile, mask_profile, hash_profile;
    logic [31:0] wb_dat_i = 0, wb_dat_o, in_data_w8, data_w8;
    logic [51:0] in_flags;
    logic [67:0] out_flags;
    logic [207:0] flag_act_mask, flag_act_value;
    logic [15:0] in_flags_ext, lkp_prof_set, mask_prof_set, hash_prof_set;
    logic [15:0] in_dest_port_tag, in_src_port_tag, dest_port_tag, src_port_tag;
    logic [19:0] alu13_prof_set, alu46_prof_set, in_hash_rotation_select, hash_rotation_select;
    logic [4:0] alu13_profile, alu46_profile;
    logic [23:0] in_qos, egress_modify_flags;
    logic [5:0] in_policer_map_two_index;
    logic [33:0] out_qos;
    logic [11:0] in_ctag_value, canonical_src_port_tag, in_pol1_idx, in_pol2_idx, pol1_idx, pol2_idx;
    logic [47:0] in_vids, out_vids, in_dest_mac_key, in_src_mac_key, in_filtering_ids;
    logic [47:0] dest_mac_lookup_key, src_mac_lookup_key, filtering_id_keys;
    logic [191:0] in_alu_ops, alu_operands;
    logic [9:0] in_pol3_idx, pol3_idx;
    logic [7:0] in_cpu_code, in_qos_vis, cpu_code, qos_vis;
    logic [111:0] in_data_w16, data_w16;
    logic [8:0] sched_flags;
    logic [1:0] pause_rx_ctrl;
    logic [117:0] cap, q[$];
    logic [1279:0] r;
    logic [2:0] ctl;
    logic [15:0] nfr;
    logic fault_seen;
    int seed, k, fail_count, checks_done;

    always #20 clk = ~clk;
    rar_stage dut_u (.*);
    rar_sink sink_u (.*);

    // --------------------
    // tasks
    // --------------------
    task put(input logic [1273:0] x);
        {in_flags, in_flags_ext, sram_fault, flag_act_en, flag_act_mask, flag_act_value,
         lkp_prof_en, lkp_prof_set, alu13_prof_en, alu13_prof_set, alu46_prof_en,
         alu46_prof_set, mask_prof_en, mask_prof_set, hash_prof_en, hash_prof_set,
         in_qos, in_policer_map_one_index, in_policer_map_two_index, in_dest_port_tag, in_src_port_tag, in_ctag_sel,
         in_ctag_value, in_vids, in_dest_mac_key, in_src_mac_key, in_filtering_ids,
         in_alu_ops, in_pol1_idx, in_pol2_idx, in_pol3_idx, in_hash_rotation_select, in_data_w8,
         in_cpu_code, in_qos_vis, in_data_w16} <= x;
    endtask

    task chkf(input logic [117:0] e, input logic [117:0] a);
        checks_done++;
        if (a !== e) begin
            fail_count++;
            $display("[ERR] %0t frame exp %h got %h", $time, e, a);
        end
    endtask

    task chkr(input logic [31:0] e, input logic [31:0] a);
        checks_done++;
        if (a !== e) begin
            fail_count++;
            $display("[ERR] %0t read exp %h got %h", $time, e, a);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hf, d};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        if (!we) chkr(e, wb_dat_o);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk);
    endtask

    // drive one beat and note its expected result
    task frame(input logic v);
        int i;
        logic [51:0] f;
        logic [3:0] p;
        for (i = 0; i < 40; i++) r[i*32+:32] = $random(seed);
        put(r[1273:0]);
        in_valid <= v;
        #1;
        if (v) begin
            f = in_flags;
            for (i = 0; i < 4; i++) if (ctl[0] && flag_act_en[i])
                f = f & flag_act_mask[i*52+:52] | flag_act_value[i*52+:52];
            if (ctl[1]) f[35:34] = in_flags[35:34];
            if (ctl[2]) f[39:36] = {|f[39:36], 3'h0};
            f[39] = f[39] | sram_fault;
            fault_seen = fault_seen | f[39];
            p = 4'h0;
            for (i = 0; i < 4; i++) if (lkp_prof_en[i]) p = lkp_prof_set[i*4+:4];
            q.push_back({in_flags_ext, f, in_policer_map_two_index, in_policer_map_one_index, in_qos, p,
                         in_ctag_sel ? in_ctag_value : in_src_port_tag[11:0]});
            nfr++;
        end
        @(posedge clk);
    endtask

    task end_sim;
        $display("checks_done %0d fail_count %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // --------------------
    // checking, watchdog and main sequence
    // --------------------
    always @(posedge clk) if (got === 1'b1) begin
        if (q.size() == 0) begin
            fail_count++;
            $display("[ERR] %0t beat without a note", $time);
        end else chkf(q.pop_front(), cap);
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim;
    end

    initial begin
        seed = 19726;
        {ctl, nfr, fault_seen} = 20'he_0000;
        {fail_count, checks_done} = 64'h0;
        put('0);
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        wb(1'b0, 4'h0, 32'h0, 32'h0000_0007);
        wb(1'b0, 4'hc, 32'h0, 32'h0000_0000);
        for (k = 0; k < 8; k++) begin
            ctl = k[2:0];
            wb(1'b1, 4'h0, {29'h0, ctl}, 32'h0);
            repeat (6) frame(1'b1);
            frame(1'b0);
            repeat (4) frame(1'b1);
            frame(1'b0);
        end
        wb(1'b0, 4'h4, 32'h0, {31'h0, fault_seen});
        wb(1'b1, 4'h4, 32'h0000_0001, 32'h0);
        wb(1'b0, 4'h4, 32'h0, 32'h0000_0000);
        wb(1'b0, 4'h8, 32'h0, {16'h0, nfr});
        end_sim;
    end
endmodule

bind rar_stage rar_chk chk_u (.*);
